// file: msi_cap_pkg.sv
// Constants and types for the interrupt message and express capability block
package msi_cap_pkg;

  // ----------------------------------------------------------------
  // Capability placement in configuration space
  // ----------------------------------------------------------------
  localparam logic [7:0] MSI_CAP_BASE = 8'h48;
  localparam logic [7:0] EXP_CAP_BASE = 8'h60;
  localparam logic [7:0] MSI_CAP_ID = 8'h05;
  localparam logic [7:0] MSI_NEXT_PTR = 8'h60;
  localparam logic [7:0] EXP_CAP_ID = 8'h10;
  localparam logic [7:0] EXP_NEXT_PTR = 8'h00;

  // ----------------------------------------------------------------
  // Relative offsets inside the interrupt message capability
  // ----------------------------------------------------------------
  localparam logic [7:0] MSI_OFS_HDR = 8'h00;
  localparam logic [7:0] MSI_OFS_ADDR_LO = 8'h04;
  localparam logic [7:0] MSI_OFS_ADDR_HI = 8'h08;
  localparam logic [7:0] MSI_OFS_DATA_32 = 8'h08;
  localparam logic [7:0] MSI_OFS_DATA_64 = 8'h0C;
  localparam logic [7:0] MSI_OFS_MASK_32 = 8'h0C;
  localparam logic [7:0] MSI_OFS_MASK_64 = 8'h10;
  localparam logic [7:0] MSI_OFS_PEND_32 = 8'h10;
  localparam logic [7:0] MSI_OFS_PEND_64 = 8'h14;

  // ----------------------------------------------------------------
  // Relative offsets inside the express capability
  // ----------------------------------------------------------------
  localparam logic [7:0] EXP_OFS_HDR = 8'h00;
  localparam logic [7:0] EXP_OFS_DEV_CAPS = 8'h04;
  localparam logic [7:0] EXP_OFS_DEV_CTL = 8'h08;
  localparam logic [7:0] EXP_OFS_LINK_CAPS = 8'h0C;
  localparam logic [7:0] EXP_OFS_LINK_CTL = 8'h10;

  // ----------------------------------------------------------------
  // Message control word fields and fixed values
  // ----------------------------------------------------------------
  localparam int CTL_MME_LSB = 4;
  localparam logic per_vector_masking_flag = 1'b1;
  localparam logic wide_message_address_flag = 1'b1;
  localparam logic WIDE_ALT_FLAG = 1'b1;
  localparam logic [2:0] MSG_CAPABLE = 3'h0;
  localparam logic [2:0] MME_RESET = 3'h0;

  // ----------------------------------------------------------------
  // Express capabilities word fields
  // ----------------------------------------------------------------
  localparam logic [4:0] EXP_MSG_NUM = 5'h00;
  localparam logic EXP_SLOT_IMPL = 1'b0;
  localparam logic [3:0] EXP_PORT_TYPE = 4'h1;
  localparam logic [3:0] EXP_VERSION = 4'h1;

  // ----------------------------------------------------------------
  // Reset values of writable registers
  // ----------------------------------------------------------------
  localparam logic [31:0] ADDR_RESET = 32'h0000_0000;
  localparam logic [15:0] DATA_RESET = 16'h0000;
  localparam logic MASK_RESET = 1'b0;
  localparam logic [15:0] CTL16_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // Carriers and states
  // ----------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } cfg_req_t;

  typedef struct packed {
    logic [63:0] addr;
    logic [15:0] data;
  } msg_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_SEND = 2'b10
  } send_state_t;

endpackage

// file: msi_express_cap.sv
// Interrupt message and express capability registers with message sender
`timescale 1ns/1ps

module msi_express_cap
  import msi_cap_pkg::*;
#(
  parameter logic [31:0] DEV_CAPS_VALUE = 32'h0000_0000,
  parameter logic [31:0] LINK_CAPS_VALUE = 32'h0000_0000
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Configuration requests from the host
  input wire cfg_req_t cfg_req,
  output logic cfg_ack,
  output logic [31:0] cfg_rdata,
  // Internal interrupt event
  input wire logic irq_req,
  // Message write towards the link
  output logic msg_valid,
  output msg_t msg,
  input wire logic msg_ready
);

  // ----------------------------------------------------------------
  // Absolute addresses
  // ----------------------------------------------------------------
  // Layout follows the wide-address flag, which is fixed high
  localparam logic [7:0] A_MSI_HDR = MSI_CAP_BASE + MSI_OFS_HDR;
  localparam logic [7:0] A_ADDR_LO = MSI_CAP_BASE + MSI_OFS_ADDR_LO;
  localparam logic [7:0] A_ADDR_HI = MSI_CAP_BASE + MSI_OFS_ADDR_HI;
  localparam logic [7:0] A_DATA = MSI_CAP_BASE +
    (wide_message_address_flag ? MSI_OFS_DATA_64 : MSI_OFS_DATA_32);
  localparam logic [7:0] A_MASK = MSI_CAP_BASE +
    (wide_message_address_flag ? MSI_OFS_MASK_64 : MSI_OFS_MASK_32);
  localparam logic [7:0] A_PEND = MSI_CAP_BASE +
    (wide_message_address_flag ? MSI_OFS_PEND_64 : MSI_OFS_PEND_32);
  localparam logic [7:0] A_EXP_HDR = EXP_CAP_BASE + EXP_OFS_HDR;
  localparam logic [7:0] A_DEV_CAPS = EXP_CAP_BASE + EXP_OFS_DEV_CAPS;
  localparam logic [7:0] A_DEV_CTL = EXP_CAP_BASE + EXP_OFS_DEV_CTL;
  localparam logic [7:0] A_LINK_CAPS = EXP_CAP_BASE + EXP_OFS_LINK_CAPS;
  localparam logic [7:0] A_LINK_CTL = EXP_CAP_BASE + EXP_OFS_LINK_CTL;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Byte-lane merge of a write into a stored word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return res;
  endfunction

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [2:0] mme_r, mme_nxt;
  logic [31:0] addr_lo_r, addr_lo_nxt;
  logic [31:0] addr_hi_r, addr_hi_nxt;
  logic [15:0] data_r, data_nxt;
  logic mask_r, mask_nxt;
  logic [15:0] dev_ctl_r, dev_ctl_nxt;
  logic [15:0] link_ctl_r, link_ctl_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic ack_r, ack_nxt;
  logic pend_r, pend_nxt;
  send_state_t state_r, state_nxt;
  logic msg_valid_r, msg_valid_nxt;
  msg_t msg_r, msg_nxt;
  logic [15:0] msi_ctl;
  logic [15:0] exp_caps;
  logic wr;
  logic rd;

  // Fixed and live fields of the two capability headers
  assign msi_ctl = {7'h00, per_vector_masking_flag, wide_message_address_flag,
                    mme_r, MSG_CAPABLE, WIDE_ALT_FLAG};
  assign exp_caps = {2'h0, EXP_MSG_NUM, EXP_SLOT_IMPL,
                     EXP_PORT_TYPE, EXP_VERSION};
  assign wr = cfg_req.valid && cfg_req.write;
  assign rd = cfg_req.valid && !cfg_req.write;

  // ----------------------------------------------------------------
  // Configuration access
  // ----------------------------------------------------------------
  // Every request is answered the next cycle; unmapped reads give zero
  always_comb begin
    mme_nxt = mme_r;
    addr_lo_nxt = addr_lo_r;
    addr_hi_nxt = addr_hi_r;
    data_nxt = data_r;
    mask_nxt = mask_r;
    dev_ctl_nxt = dev_ctl_r;
    link_ctl_nxt = link_ctl_r;
    ack_nxt = cfg_req.valid;
    rdata_nxt = 32'h0000_0000;
    if (wr) begin
      case (cfg_req.addr)
        A_MSI_HDR: begin
          if (cfg_req.be[2]) begin
            mme_nxt = cfg_req.wdata[16 + CTL_MME_LSB +: 3];
          end
        end
        A_ADDR_LO: begin
          // Low two bits stay zero: the target is word aligned
          addr_lo_nxt = merge(addr_lo_r, cfg_req.wdata, cfg_req.be) &
                        32'hFFFF_FFFC;
        end
        A_ADDR_HI: addr_hi_nxt = merge(addr_hi_r, cfg_req.wdata, cfg_req.be);
        A_DATA: data_nxt = merge({16'h0000, data_r}, cfg_req.wdata,
                                 cfg_req.be)[15:0];
        A_MASK: begin
          // Only vector 0 exists, so only its mask bit is kept
          if (cfg_req.be[0]) begin
            mask_nxt = cfg_req.wdata[0];
          end
        end
        A_DEV_CTL: dev_ctl_nxt = merge({16'h0000, dev_ctl_r}, cfg_req.wdata,
                                       cfg_req.be)[15:0];
        A_LINK_CTL: link_ctl_nxt = merge({16'h0000, link_ctl_r}, cfg_req.wdata,
                                         cfg_req.be)[15:0];
        default: begin
        end
      endcase
    end
    if (rd) begin
      case (cfg_req.addr)
        A_MSI_HDR: rdata_nxt = {msi_ctl, MSI_NEXT_PTR, MSI_CAP_ID};
        A_ADDR_LO: rdata_nxt = addr_lo_r;
        A_ADDR_HI: rdata_nxt = addr_hi_r;
        A_DATA: rdata_nxt = {16'h0000, data_r};
        A_MASK: rdata_nxt = {31'h0000_0000, mask_r};
        A_PEND: rdata_nxt = {31'h0000_0000, pend_r};
        A_EXP_HDR: rdata_nxt = {exp_caps, EXP_NEXT_PTR, EXP_CAP_ID};
        A_DEV_CAPS: rdata_nxt = DEV_CAPS_VALUE;
        A_DEV_CTL: rdata_nxt = {16'h0000, dev_ctl_r};
        A_LINK_CAPS: rdata_nxt = LINK_CAPS_VALUE;
        A_LINK_CTL: rdata_nxt = {16'h0000, link_ctl_r};
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // Register the configuration state and the answer
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mme_r <= MME_RESET;
      addr_lo_r <= ADDR_RESET;
      addr_hi_r <= ADDR_RESET;
      data_r <= DATA_RESET;
      mask_r <= MASK_RESET;
      dev_ctl_r <= CTL16_RESET;
      link_ctl_r <= CTL16_RESET;
      rdata_r <= 32'h0000_0000;
      ack_r <= 1'b0;
    end else begin
      mme_r <= mme_nxt;
      addr_lo_r <= addr_lo_nxt;
      addr_hi_r <= addr_hi_nxt;
      data_r <= data_nxt;
      mask_r <= mask_nxt;
      dev_ctl_r <= dev_ctl_nxt;
      link_ctl_r <= link_ctl_nxt;
      rdata_r <= rdata_nxt;
      ack_r <= ack_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Message sender
  // ----------------------------------------------------------------
  // No sideband wire exists: every interrupt leaves as a memory write
  // A new event in the cycle the message is taken keeps pending set
  always_comb begin
    state_nxt = state_r;
    msg_valid_nxt = msg_valid_r;
    msg_nxt = msg_r;
    pend_nxt = pend_r;
    case (state_r)
      ST_IDLE: begin
        // Pending launches as soon as the vector is unmasked
        if (pend_r && !mask_r) begin
          state_nxt = ST_SEND;
          msg_valid_nxt = 1'b1;
          msg_nxt.addr = {addr_hi_r, addr_lo_r};
          msg_nxt.data = data_r;
        end
      end
      ST_SEND: begin
        if (msg_ready) begin
          state_nxt = ST_IDLE;
          msg_valid_nxt = 1'b0;
          pend_nxt = 1'b0;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
        msg_valid_nxt = 1'b0;
      end
    endcase
    if (irq_req) begin
      pend_nxt = 1'b1;
    end
  end

  // Register the sender state
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_r <= ST_IDLE;
      msg_valid_r <= 1'b0;
      msg_r <= '0;
      pend_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      msg_valid_r <= msg_valid_nxt;
      msg_r <= msg_nxt;
      pend_r <= pend_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign cfg_ack = ack_r;
  assign cfg_rdata = rdata_r;
  assign msg_valid = msg_valid_r;
  assign msg = msg_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  property p_msi_id;
    rd && cfg_req.addr == A_MSI_HDR |=> cfg_ack && cfg_rdata[7:0] == 8'h05;
  endproperty
  a_msi_id: assert property (p_msi_id)
    else $error("message capability identifier wrong");

  property p_msi_next;
    rd && cfg_req.addr == 8'h48 |=> cfg_rdata[15:8] == 8'h60;
  endproperty
  a_msi_next: assert property (p_msi_next)
    else $error("message next pointer wrong");

  property p_msi_ctl_fixed;
    rd && cfg_req.addr == A_MSI_HDR |=>
      cfg_rdata[24] && cfg_rdata[23] && cfg_rdata[19:17] == 3'h0 && cfg_rdata[16]
      && cfg_rdata[31:25] == 7'h00;
  endproperty
  a_msi_ctl_fixed: assert property (p_msi_ctl_fixed)
    else $error("message control fixed bits wrong");

  property p_mme_write;
    wr && cfg_req.addr == A_MSI_HDR && cfg_req.be[2] ##1 rd && cfg_req.addr == A_MSI_HDR
      |=> cfg_rdata[22:20] == $past(cfg_req.wdata[22:20], 2);
  endproperty
  a_mme_write: assert property (p_mme_write)
    else $error("allowed message count not stored");

  property p_exp_hdr;
    rd && cfg_req.addr == 8'h60 |=> cfg_rdata == 32'h0011_0010;
  endproperty
  a_exp_hdr: assert property (p_exp_hdr)
    else $error("express header wrong");

  property p_mask_blocks;
    !msg_valid ##1 msg_valid |-> $past(!mask_r);
  endproperty
  a_mask_blocks: assert property (p_mask_blocks)
    else $error("message launched while masked");

  property p_pend_set;
    irq_req |=> pend_r;
  endproperty
  a_pend_set: assert property (p_pend_set)
    else $error("pending not set by event");

  property p_unmask_sends;
    pend_r && !mask_r && !msg_valid |=> msg_valid;
  endproperty
  a_unmask_sends: assert property (p_unmask_sends)
    else $error("unmasked pending vector not sent");

  property p_payload;
    $rose(msg_valid) |-> msg.data == $past(data_r)
      && msg.addr == {$past(addr_hi_r), $past(addr_lo_r)};
  endproperty
  a_payload: assert property (p_payload)
    else $error("message payload or address wrong");

  property p_hold;
    msg_valid && !msg_ready |=> msg_valid && $stable(msg);
  endproperty
  a_hold: assert property (p_hold)
    else $error("message dropped before accepted");

  property p_data_ofs;
    wr && cfg_req.addr == 8'h54 && cfg_req.be == 4'hF ##1 rd && cfg_req.addr == 8'h54
      |=> cfg_rdata[15:0] == $past(cfg_req.wdata[15:0], 2);
  endproperty
  a_data_ofs: assert property (p_data_ofs)
    else $error("data register not at wide offset");

endmodule

// file: host_model.sv
// Host model: configuration requester and message sink
`timescale 1ns/1ps

module host_model
  import msi_cap_pkg::*;
(
  // Clock
  input wire logic sys_clk,
  // Configuration requests
  output cfg_req_t cfg_req,
  // Message sink
  input wire logic stall_en,
  output logic msg_ready
);

  // ----------------------------------------------------------------
  // Message acceptance
  // ----------------------------------------------------------------
  integer seed = 71399;

  initial begin
    cfg_req = '0;
    msg_ready = 1'b0;
  end

  // Random stalls prove the message holds while refused
  always @(posedge sys_clk) begin
    msg_ready <= stall_en ? 1'($random(seed)) : 1'b1;
  end

  // ----------------------------------------------------------------
  // Configuration request
  // ----------------------------------------------------------------
  // One request per call; idle fields carry inverted junk, not the old value
  task automatic issue(input logic w, input logic [7:0] a, input logic [3:0] be,
                       input logic [31:0] d);
    @(posedge sys_clk);
    cfg_req <= {1'b1, w, a, be, d};
    @(posedge sys_clk);
    cfg_req <= {1'b0, ~cfg_req[44:0]};
  endtask

endmodule

// file: msi_express_cap_test.sv
// Self-checking testbench for the interrupt message and express capability block
`timescale 1ns/1ps

module msi_express_cap_test
  import msi_cap_pkg::*;
;

  // ----------------------------------------------------------------
  // Signals and bookkeeping
  // ----------------------------------------------------------------
  localparam logic [31:0] DEV_CAPS = 32'h0ABC_1234;
  localparam logic [31:0] LINK_CAPS = 32'h5A5A_C3C3;
  logic sys_clk;
  logic rst;
  cfg_req_t cfg_req;
  logic cfg_ack;
  logic [31:0] cfg_rdata;
  logic irq_req;
  logic msg_valid;
  msg_t msg;
  logic msg_ready;
  logic stall_en;
  int n_errors = 0;
  int n_compared = 0;
  integer seed = 71399;
  logic [31:0] rq[$];
  logic [79:0] mq[$];
  logic [31:0] lo;
  logic [31:0] hi;
  logic [31:0] dv;

  msi_express_cap #(.DEV_CAPS_VALUE(DEV_CAPS), .LINK_CAPS_VALUE(LINK_CAPS)) dut (
    .sys_clk(sys_clk), .rst(rst), .cfg_req(cfg_req), .cfg_ack(cfg_ack),
    .cfg_rdata(cfg_rdata), .irq_req(irq_req), .msg_valid(msg_valid), .msg(msg),
    .msg_ready(msg_ready));

  host_model u_host (.sys_clk(sys_clk), .cfg_req(cfg_req), .stall_en(stall_en),
    .msg_ready(msg_ready));

  // 50 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [79:0] seen, input logic [79:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tally_and_finish;
    $display("Checks: %0d compared, %0d errors", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Expectation is noted before the request, so the monitor never runs dry
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    rq.push_back(exp);
    u_host.issue(1'b0, a, 4'hF, 32'h0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    rq.push_back(32'h0);
    u_host.issue(1'b1, a, be, d);
  endtask

  task automatic pulse;
    @(posedge sys_clk);
    irq_req <= 1'b1;
    @(posedge sys_clk);
    irq_req <= 1'b0;
  endtask

  // Bounded wait until every noted answer and message has shown up
  task automatic drain;
    int k;
    k = 0;
    while ((rq.size() != 0 || mq.size() != 0) && k < 300) begin
      @(posedge sys_clk);
      k++;
    end
    check("drain", 80'(k == 300), 80'h0);
  endtask

  // ----------------------------------------------------------------
  // Output monitor
  // ----------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (cfg_ack === 1'b1) begin
      if (rq.size() == 0)
        check("cfg_ack", 80'h1, 80'h0);
      else
        check("cfg_rdata", 80'(cfg_rdata), 80'(rq.pop_front()));
    end
    if (msg_valid === 1'b1 && msg_ready === 1'b1) begin
      if (mq.size() == 0)
        check("msg_valid", 80'h1, 80'h0);
      else
        check("msg", msg, mq.pop_front());
    end
  end

  // Hang guard, well beyond the few hundred cycles the sequence needs
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_errors++;
    tally_and_finish;
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    irq_req = 1'b0;
    stall_en = 1'b0;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    // Fixed headers, parameters, reset values and unmapped holes
    rd(8'h48, 32'h0181_6005);
    rd(8'h60, 32'h0011_0010);
    rd(8'h64, DEV_CAPS);
    rd(8'h6C, LINK_CAPS);
    for (int i = 0; i < 5; i++) begin
      rd(8'h4C + 8'(4 * i), 32'h0);
    end
    rd(8'h40, 32'h0);
    rd(8'h74, 32'h0);
    // Writes to read-only words and holes change nothing
    wr(8'h60, 4'hF, 32'hFFFF_FFFF);
    wr(8'h5C, 4'hF, 32'hFFFF_FFFF);
    wr(8'h74, 4'hF, 32'hFFFF_FFFF);
    rd(8'h60, 32'h0011_0010);
    rd(8'h5C, 32'h0);
    rd(8'h74, 32'h0);
    // Every allowed-count code; other control bits stay fixed
    for (int v = 0; v < 8; v++) begin
      wr(8'h48, 4'hF, 32'hFF8F_FFFF | (32'(v) << 20));
      rd(8'h48, 32'h0181_6005 | (32'(v) << 20));
    end
    wr(8'h48, 4'hB, 32'h0);
    rd(8'h48, 32'h01F1_6005);
    // Express control words: low half writable, status half reads 0
    wr(8'h68, 4'hF, 32'hFFFF_FFFF);
    wr(8'h70, 4'hF, 32'hFFFF_FFFF);
    rd(8'h68, 32'h0000_FFFF);
    rd(8'h70, 32'h0000_FFFF);
    // Random address and pattern, with and without sink stalls
    for (int i = 0; i < 6; i++) begin
      lo = $random(seed);
      hi = $random(seed);
      dv = $random(seed);
      stall_en <= i[0];
      wr(8'h4C, 4'hF, lo);
      wr(8'h50, 4'hF, hi);
      wr(8'h54, 4'hF, dv);
      rd(8'h4C, lo & 32'hFFFF_FFFC);
      rd(8'h50, hi);
      rd(8'h54, {16'h0, dv[15:0]});
      mq.push_back({hi, lo & 32'hFFFF_FFFC, dv[15:0]});
      pulse;
      drain;
    end
    // Only the enabled byte lane of the pattern changes
    wr(8'h54, 4'h1, 32'hFFFF_FFFF);
    rd(8'h54, {16'h0, dv[15:8], 8'hFF});
    // Masked event waits as pending, unmasking releases it
    wr(8'h58, 4'hF, 32'hFFFF_FFFF);
    rd(8'h58, 32'h1);
    pulse;
    repeat (10) @(posedge sys_clk);
    rd(8'h5C, 32'h1);
    drain;
    mq.push_back({hi, lo & 32'hFFFF_FFFC, dv[15:8], 8'hFF});
    wr(8'h58, 4'hF, 32'h0);
    drain;
    rd(8'h5C, 32'h0);
    drain;
    // Second reset in mid-run restores the writable words
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    rd(8'h48, 32'h0181_6005);
    rd(8'h4C, 32'h0);
    rd(8'h54, 32'h0);
    drain;
    tally_and_finish;
  end

endmodule
